// file: shared/tlbu_defines.vh
// Constants for the translation unit: coprocessor register numbers, field
// positions, descriptor encodings, fault codes.
// Assumes inclusion by bare name from the design files.
`ifndef TLBU_DEFINES_VH
`define TLBU_DEFINES_VH
`define TLBU_CP_NUM        4'hF
`define TLBU_REG_CTRL      3'h1
`define TLBU_REG_TBASE     3'h2
`define TLBU_REG_DOMAIN    3'h3
`define TLBU_REG_FSTAT     3'h5
`define TLBU_REG_FADDR     3'h6
`define TLBU_REG_HI_BIT    3
`define TLBU_CTRL_MMU_BIT  0
`define TLBU_CTRL_IDC_BIT  2
`define TLBU_CTRL_WB_BIT   3
`define TLBU_CTRL_RESET    32'h00000000
`define TLBU_TBASE_MASK    32'hFFFFC000
`define TLBU_KIND_SECTION  2'h0
`define TLBU_KIND_SMALL    2'h1
`define TLBU_KIND_LARGE    2'h2
`define TLBU_DOM_NOACC     2'h0
`define TLBU_DOM_CLIENT    2'h1
`define TLBU_DOM_MANAGER   2'h3
`define TLBU_AP_NONE       2'h0
`define TLBU_AP_PRIV       2'h1
`define TLBU_AP_READ       2'h2
`define TLBU_FS_DOMAIN     7:4
`define TLBU_FS_TYPE       3:1
`define TLBU_FS_EXT_BIT    0
`define TLBU_FT_DOMAIN     3'h4
`define TLBU_FT_PERM       3'h6
`define TLBU_FT_WALK       3'h2
`define TLBU_FT_EXTERNAL   3'h0
`endif

// file: verilog/tlbu_entry_match.v
// One buffer entry compare: matches a virtual address against an entry tag
// sized by its mapping kind, and yields physical address and subpage perms.
// Assumes the caller holds the entry storage and picks one hit.
`include "tlbu_defines.vh"
module tlbu_entry_match (
  input  wire        valid,
  input  wire [1:0]  kind,
  input  wire [31:0] vtag,
  input  wire [31:0] pbase,
  input  wire [7:0]  ap_all,
  input  wire [31:0] vaddr,
  output reg         hit,
  output reg  [31:0] paddr,
  output reg  [1:0]  ap
);
  always @* begin
    hit   = 1'b0;
    paddr = vaddr;
    ap    = ap_all[1:0];
    case (kind)
      `TLBU_KIND_SECTION: begin
        hit   = valid && (vtag[31:20] == vaddr[31:20]);
        paddr = {pbase[31:20], vaddr[19:0]};
        ap    = ap_all[1:0];
      end
      `TLBU_KIND_SMALL: begin
        hit   = valid && (vtag[31:12] == vaddr[31:12]);
        paddr = {pbase[31:12], vaddr[11:0]};
        ap    = ap_all[{vaddr[11:10], 1'b0} +: 2];
      end
      `TLBU_KIND_LARGE: begin
        hit   = valid && (vtag[31:16] == vaddr[31:16]);
        paddr = {pbase[31:16], vaddr[15:0]};
        ap    = ap_all[{vaddr[15:14], 1'b0} +: 2];
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end
endmodule

// file: verilog/tlbu_unit.v
// Translation unit: look-aside buffer, domain permission check, walk
// handshake and system coprocessor registers.
// Assumes the core holds requests until done or abort, and an external
// walker answers walk requests with a complete entry.
//
// Contract
// - Buffer holds 64 entries feeding access checks
// - Permitted hit drives translated physical address
// - Denied access aborts core, no memory access
// - Miss starts walk, result written to entry
// - Replacement pointer steps round-robin through entries
// - Translation off passes virtual address unchanged
// - Sections 1MB, small 4KB, large 64KB pages
// - Subpage permissions: 1KB small, 16KB large
// - Domain register: sixteen two-bit rights fields
// - Registers 32-bit, coprocessor moves only
// - Table base 16KB aligned physical address
// - Fault status: domain 7:4, type 3:1
// - Bit 0 marks external fault; type encoding
// - Fault status write flushes whole buffer
// - Fault address captures faulting virtual address
// - Fault address write purges matching entry
// - Fault registers update on data faults only
// - Other coprocessor moves raise undefined trap
// - Control bit0 translation, bit2 cache, bit3 buffer; cache and buffer enables also need bit0
`include "tlbu_defines.vh"
module tlbu_unit #(
  parameter ENTRIES = 64,
  parameter IDX_W   = 6
) (
  input  wire        ref_clk,
  input  wire        reset,
  // Core access request
  input  wire        acc_req,
  input  wire [31:0] acc_vaddr,
  input  wire        acc_write,
  input  wire        acc_priv,
  input  wire        acc_fetch,
  output reg         acc_done,
  output reg         acc_abort,
  output reg  [31:0] acc_paddr,
  // Coprocessor moves
  input  wire        cp_req,
  input  wire [3:0]  cp_num,
  input  wire [3:0]  cp_reg,
  input  wire        cp_write,
  input  wire [31:0] cp_wdata,
  output reg         cp_ack,
  output reg         cp_undef,
  output reg  [31:0] cp_rdata,
  // Walk handshake
  output reg         walk_req,
  output reg  [31:0] walk_vaddr,
  output reg  [31:0] walk_table_base,
  input  wire        walk_done,
  input  wire        walk_fault,
  input  wire [2:0]  walk_ftype,
  input  wire        walk_ext,
  input  wire [1:0]  walk_kind,
  input  wire [31:0] walk_pbase,
  input  wire [3:0]  walk_domain,
  input  wire [7:0]  walk_ap,
  // Control outputs
  output reg         cache_enable,
  output reg         wbuf_enable
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WALK = 3'b010;
  localparam ST_FILL = 3'b100;

  reg [2:0]  state_r;
  reg [31:0] ctrl_r;
  reg [31:0] tbase_r;
  reg [31:0] domain_r;
  reg [7:0]  fstat_r;
  reg [31:0] faddr_r;
  reg [IDX_W-1:0] repl_r;

  reg             ent_valid [0:ENTRIES-1];
  reg [1:0]       ent_kind  [0:ENTRIES-1];
  reg [31:0]      ent_vtag  [0:ENTRIES-1];
  reg [31:0]      ent_pbase [0:ENTRIES-1];
  reg [3:0]       ent_dom   [0:ENTRIES-1];
  reg [7:0]       ent_ap    [0:ENTRIES-1];

  wire [ENTRIES-1:0] hit_vec;
  wire [ENTRIES-1:0] purge_vec;
  wire [31:0]        pa_vec [0:ENTRIES-1];
  wire [1:0]         ap_vec [0:ENTRIES-1];

  // Purge is only issued from idle, so one comparator set per entry serves both;
  // off in the answer cycle, where a waiting access may be taken on its own address
  wire        purge_go = cp_req && !cp_ack && !cp_undef && cp_write &&
                         (cp_num == `TLBU_CP_NUM) && (cp_reg[2:0] == `TLBU_REG_FADDR) &&
                         !cp_reg[`TLBU_REG_HI_BIT];
  wire [31:0] cmp_addr = purge_go ? cp_wdata : acc_vaddr;

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : g_ent
      tlbu_entry_match u_match (
        .valid  (ent_valid[g]),
        .kind   (ent_kind[g]),
        .vtag   (ent_vtag[g]),
        .pbase  (ent_pbase[g]),
        .ap_all (ent_ap[g]),
        .vaddr  (cmp_addr),
        .hit    (hit_vec[g]),
        .paddr  (pa_vec[g]),
        .ap     (ap_vec[g])
      );
      assign purge_vec[g] = hit_vec[g] & purge_go;
    end
  endgenerate

  // Lowest hit wins; a fill never duplicates a live tag
  reg             any_hit;
  reg [IDX_W-1:0] hit_idx;
  integer k;
  always @* begin
    any_hit = 1'b0;
    hit_idx = {IDX_W{1'b0}};
    for (k = ENTRIES - 1; k >= 0; k = k - 1) begin
      if (hit_vec[k]) begin
        any_hit = 1'b1;
        hit_idx = k[IDX_W-1:0];
      end
    end
  end

  // Domain and permission check for a hit
  wire [3:0]  h_dom  = ent_dom[hit_idx];
  wire [1:0]  h_ap   = ap_vec[hit_idx];
  wire [1:0]  h_drt  = domain_r[{h_dom, 1'b0} +: 2];
  reg         perm_ok;
  reg [2:0]   perm_ft;
  always @* begin
    perm_ok = 1'b0;
    perm_ft = `TLBU_FT_DOMAIN;
    case (h_drt)
      `TLBU_DOM_MANAGER: perm_ok = 1'b1;
      `TLBU_DOM_CLIENT: begin
        perm_ft = `TLBU_FT_PERM;
        case (h_ap)
          `TLBU_AP_NONE: perm_ok = 1'b0;
          `TLBU_AP_PRIV: perm_ok = acc_priv;
          `TLBU_AP_READ: perm_ok = acc_priv || !acc_write;
          default: perm_ok = 1'b1;
        endcase
      end
      default: perm_ok = 1'b0;
    endcase
  end

  wire mmu_on = ctrl_r[`TLBU_CTRL_MMU_BIT];
  wire cp_own = (cp_num == `TLBU_CP_NUM) && !cp_reg[`TLBU_REG_HI_BIT];
  reg [31:0] rd_nxt;
  always @* begin
    case (cp_reg[2:0])
      `TLBU_REG_FSTAT: rd_nxt = {24'h000000, fstat_r};
      `TLBU_REG_FADDR: rd_nxt = faddr_r;
      default:         rd_nxt = 32'h00000000;
    endcase
  end

  integer i;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r         <= ST_IDLE;
      ctrl_r          <= `TLBU_CTRL_RESET;
      tbase_r         <= 32'h00000000;
      domain_r        <= 32'h00000000;
      fstat_r         <= 8'h00;
      faddr_r         <= 32'h00000000;
      repl_r          <= {IDX_W{1'b0}};
      acc_done        <= 1'b0;
      acc_abort       <= 1'b0;
      acc_paddr       <= 32'h00000000;
      cp_ack          <= 1'b0;
      cp_undef        <= 1'b0;
      cp_rdata        <= 32'h00000000;
      walk_req        <= 1'b0;
      walk_vaddr      <= 32'h00000000;
      walk_table_base <= 32'h00000000;
      cache_enable    <= 1'b0;
      wbuf_enable     <= 1'b0;
      for (i = 0; i < ENTRIES; i = i + 1) begin
        ent_valid[i] <= 1'b0;
        ent_kind[i]  <= 2'h0;
        ent_vtag[i]  <= 32'h00000000;
        ent_pbase[i] <= 32'h00000000;
        ent_dom[i]   <= 4'h0;
        ent_ap[i]    <= 8'h00;
      end
    end else begin
      acc_done  <= 1'b0;
      acc_abort <= 1'b0;
      cp_ack    <= 1'b0;
      cp_undef  <= 1'b0;
      cache_enable <= ctrl_r[`TLBU_CTRL_MMU_BIT] & ctrl_r[`TLBU_CTRL_IDC_BIT];
      wbuf_enable  <= ctrl_r[`TLBU_CTRL_MMU_BIT] & ctrl_r[`TLBU_CTRL_WB_BIT];
      case (state_r)
        ST_IDLE: begin
          // Coprocessor moves take priority; core waits one cycle
          if (cp_req && !cp_ack && !cp_undef) begin
            if (!cp_own) begin
              cp_undef <= 1'b1;
            end else begin
              cp_ack   <= 1'b1;
              cp_rdata <= rd_nxt;
              if (cp_write) begin
                case (cp_reg[2:0])
                  `TLBU_REG_CTRL:   ctrl_r   <= cp_wdata;
                  `TLBU_REG_TBASE:  tbase_r  <= cp_wdata & `TLBU_TBASE_MASK;
                  `TLBU_REG_DOMAIN: domain_r <= cp_wdata;
                  `TLBU_REG_FSTAT: begin
                    for (i = 0; i < ENTRIES; i = i + 1)
                      ent_valid[i] <= 1'b0;
                  end
                  `TLBU_REG_FADDR: begin
                    for (i = 0; i < ENTRIES; i = i + 1)
                      if (purge_vec[i]) ent_valid[i] <= 1'b0;
                  end
                  default: ;
                endcase
              end
            end
          end else if (acc_req && !acc_done && !acc_abort) begin
            if (!mmu_on) begin
              acc_paddr <= acc_vaddr;
              acc_done  <= 1'b1;
            end else if (any_hit) begin
              if (perm_ok) begin
                acc_paddr <= pa_vec[hit_idx];
                acc_done  <= 1'b1;
              end else begin
                acc_abort <= 1'b1;
                if (!acc_fetch) begin
                  fstat_r <= {h_dom, perm_ft, 1'b0};
                  faddr_r <= acc_vaddr;
                end
              end
            end else begin
              walk_req        <= 1'b1;
              walk_vaddr      <= acc_vaddr;
              walk_table_base <= tbase_r;
              state_r         <= ST_WALK;
            end
          end
        end
        ST_WALK: begin
          if (walk_done) begin
            walk_req <= 1'b0;
            if (walk_fault) begin
              acc_abort <= 1'b1;
              state_r   <= ST_IDLE;
              if (!acc_fetch) begin
                fstat_r <= {walk_domain, walk_ftype, walk_ext};
                faddr_r <= walk_vaddr;
              end
            end else begin
              ent_valid[repl_r] <= 1'b1;
              ent_kind[repl_r]  <= walk_kind;
              ent_vtag[repl_r]  <= walk_vaddr;
              ent_pbase[repl_r] <= walk_pbase;
              ent_dom[repl_r]   <= walk_domain;
              ent_ap[repl_r]    <= walk_ap;
              repl_r            <= repl_r + 1'b1;
              state_r           <= ST_FILL;
            end
          end
        end
        ST_FILL: begin
          // Retry from idle; the new entry now hits and is checked
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// file: testbench/tlbu_unit_sva.sv
// Checker for tlbu_unit: access answers, walk handshake, trap decode.
// Assumes it is bound to tlbu_unit and sees only its ports.
module tlbu_unit_sva #(
  parameter ENTRIES = 64,
  parameter IDX_W   = 6
) (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        acc_req,
  input wire logic [31:0] acc_vaddr,
  input wire logic        acc_done,
  input wire logic        acc_abort,
  input wire logic        cp_req,
  input wire logic [3:0]  cp_num,
  input wire logic [3:0]  cp_reg,
  input wire logic        cp_ack,
  input wire logic        cp_undef,
  input wire logic        walk_req,
  input wire logic [31:0] walk_vaddr,
  input wire logic [31:0] walk_table_base,
  input wire logic        walk_done,
  input wire logic        walk_fault
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  answer_one_a: assert property (!(acc_done && acc_abort)) else $error("done with abort");
  answer_req_a: assert property (acc_done || acc_abort |-> acc_req) else $error("stray answer");
  trap_cause_a: assert property (cp_undef |-> cp_num != 4'hF || cp_reg[3])
    else $error("bad trap");
  ack_cause_a: assert property (cp_ack |-> $past(cp_req) && cp_num == 4'hF && !cp_reg[3])
    else $error("bad ack");
  walk_start_a: assert property ($rose(walk_req) |-> acc_req && walk_vaddr == acc_vaddr)
    else $error("walk without access");
  base_align_a: assert property (walk_req |-> walk_table_base[13:0] == 14'h0)
    else $error("base unaligned");
  walk_hold_a: assert property (walk_req && !walk_done |=> walk_req && $stable(walk_vaddr))
    else $error("walk dropped");
  walk_drop_a: assert property (walk_req && walk_done |=> !walk_req) else $error("walk stuck");
  walk_fault_a: assert property (walk_req && walk_done && walk_fault |=> acc_abort)
    else $error("walk fault not aborted");
  walk_retry_a: assert property (walk_req && walk_done && !walk_fault |-> ##3 acc_done || acc_abort)
    else $error("no answer after fill");
  cover property (walk_req && walk_done);
  cover property (acc_abort);
  cover property (cp_undef);
endmodule

bind tlbu_unit tlbu_unit_sva #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) chk_u (.*);

// file: testbench/tlbu_walk_model.sv
// Walk partner: answers each walk request dly+1 cycles after it is raised, with cfg fields.
// Assumes the bench changes cfg and dly only while no walk is pending.
module tlbu_walk_model (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        walk_req,
  output logic             walk_done,
  output logic             walk_fault,
  output logic [2:0]       walk_ftype,
  output logic             walk_ext,
  output logic [1:0]       walk_kind,
  output logic [31:0]      walk_pbase,
  output logic [3:0]       walk_domain,
  output logic [7:0]       walk_ap
);
  logic [50:0] cfg = 51'h0;
  logic [50:0] flds = 51'h0;
  logic [3:0]  dly = 4'h3;
  logic [3:0]  cnt;
  assign {walk_fault, walk_ftype, walk_ext, walk_kind, walk_pbase, walk_domain, walk_ap} = flds;
  always @(posedge ref_clk or posedge reset)
    if (reset) begin
      walk_done <= 1'b0;
      cnt <= 4'h0;
    end else if (walk_done) begin
      walk_done <= 1'b0;
      cnt <= 4'h0;
      // Stale fields flip so a late sample cannot pass by luck
      flds <= ~flds;
    end else if (walk_req && cnt == dly) begin
      walk_done <= 1'b1;
      flds <= cfg;
    end else if (walk_req)
      cnt <= cnt + 4'h1;
endmodule

// file: testbench/test_mmu_tlb_and_control_regs.sv
// Bench for tlbu_unit: core-side tasks drive accesses and coprocessor moves.
// Assumes the walk model answers every walk from its settings.
module test_mmu_tlb_and_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, reset = 1'b1;
  logic acc_req = 1'b0, acc_write = 1'b0, acc_priv = 1'b0, acc_fetch = 1'b0;
  logic cp_req = 1'b0, cp_write = 1'b0;
  logic [3:0] cp_num = 4'h0, cp_reg = 4'h0;
  logic [31:0] acc_vaddr = 32'h0, cp_wdata = 32'h0;
  logic acc_done, acc_abort, cp_ack, cp_undef, walk_req, walk_done, walk_fault, walk_ext;
  logic [31:0] acc_paddr, cp_rdata, walk_vaddr, walk_table_base, walk_pbase, rd, base;
  logic [2:0] walk_ftype;
  logic [1:0] walk_kind, r;
  logic [3:0] walk_domain;
  logic [7:0] walk_ap;
  logic cache_enable, wbuf_enable, w;
  logic [7:0] tr [4] = '{8'hE1, 8'hF8, 8'h01, 8'hF2};
  int mismatches = 0, n_tests = 0;
  always #2 ref_clk = ~ref_clk;
  tlbu_unit dut_u (.*);
  tlbu_walk_model walker_u (.*);
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic acc(input logic [31:0] va, input logic [2:0] f);
    @(posedge ref_clk);
    acc_req <= 1'b1;
    acc_vaddr <= va;
    {acc_fetch, acc_write, acc_priv} <= f;
    r = 2'b00;
    w = 1'b0;
    for (int n = 0; n < 99 && r == 2'b00; n++) begin
      @(posedge ref_clk);
      #1;
      if (walk_req) base = walk_table_base;
      w = w | walk_req;
      r = {acc_abort, acc_done};
    end
    if (r == 2'b00) chk(32'h0, 32'h1, "no access answer");
    @(posedge ref_clk);
    acc_req <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic cp(input logic [7:0] nr, input logic wr, input logic [31:0] wd);
    @(posedge ref_clk);
    cp_req <= 1'b1;
    {cp_num, cp_reg} <= nr;
    cp_write <= wr;
    cp_wdata <= wd;
    r = 2'b00;
    for (int n = 0; n < 99 && r == 2'b00; n++) begin
      @(posedge ref_clk);
      #1;
      r = {cp_undef, cp_ack};
    end
    if (r == 2'b00) chk(32'h0, 32'h1, "no move answer");
    rd = cp_rdata;
    @(posedge ref_clk);
    cp_req <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wcfg(input logic [1:0] k, input logic [31:0] pb, input logic [3:0] dm,
                      input logic [7:0] ap);
    walker_u.cfg = {5'h0, k, pb, dm, ap};
  endtask
  task automatic t_boot();
    chk({30'h0, cache_enable, wbuf_enable}, 32'h0, "enables");
    acc(32'h12345678, 3'h1);
    chk({29'h0, w, r}, 32'h1, "bypass");
    chk(acc_paddr, 32'h12345678, "bypass addr");
    $display("t_boot done");
  endtask
  task automatic t_regs();
    cp(8'hF1, 1'b1, 32'h0000000D);
    chk({30'h0, cache_enable, wbuf_enable}, 32'h3, "enables");
    cp(8'hF1, 1'b0, 32'h0);
    chk(rd, 32'h0, "control read");
    for (int j = 0; j < 4; j++) begin
      cp(tr[j], 1'b0, 32'h0);
      chk({30'h0, r}, (tr[j][7:4] != 4'hF || tr[j][3]) ? 32'h2 : 32'h1, "trap");
    end
    cp(8'hF2, 1'b1, 32'h12345ABC);
    cp(8'hF3, 1'b1, 32'hC0000031);
    $display("t_regs done");
  endtask
  task automatic t_map();
    wcfg(2'h0, 32'hABC00000, 4'h0, 8'hFF);
    acc(32'h00101234, 3'h0);
    chk({29'h0, w, r}, 32'h5, "section miss");
    chk(acc_paddr, 32'hABC01234, "section pa");
    chk(base, 32'h12344000, "table base");
    acc(32'h00101234, 3'h0);
    chk({29'h0, w, r}, 32'h1, "section hit");
    wcfg(2'h1, 32'h55555000, 4'h0, 8'h0C);
    acc(32'h00203456, 3'h0);
    chk(acc_paddr, 32'h55555456, "small pa");
    acc(32'h00203056, 3'h0);
    chk({29'h0, w, r}, 32'h2, "small subpage denied");
    cp(8'hF5, 1'b0, 32'h0);
    chk(rd, 32'h0000000C, "perm status");
    wcfg(2'h2, 32'h77770000, 4'h0, 8'h30);
    acc(32'h0030ABCD, 3'h0);
    chk(acc_paddr, 32'h7777ABCD, "large pa");
    acc(32'h00300BCD, 3'h0);
    chk({29'h0, w, r}, 32'h2, "large subpage denied");
    $display("t_map done");
  endtask
  task automatic t_fault();
    wcfg(2'h0, 32'h00A00000, 4'h1, 8'hFF);
    acc(32'h00A00010, 3'h1);
    chk({30'h0, r}, 32'h2, "domain abort");
    acc(32'h00B00020, 3'h5);
    cp(8'hF5, 1'b0, 32'h0);
    chk(rd, 32'h00000018, "domain status");
    cp(8'hF6, 1'b0, 32'h0);
    chk(rd, 32'h00A00010, "fault address");
    walker_u.cfg[50:46] = 5'h1B;
    acc(32'h00C00030, 3'h1);
    cp(8'hF5, 1'b0, 32'h0);
    chk({28'h0, rd[3:0]}, 32'hB, "external status");
    $display("t_fault done");
  endtask
  task automatic t_perm();
    wcfg(2'h0, 32'h00D00000, 4'hF, 8'h00);
    acc(32'h00D00040, 3'h2);
    chk({29'h0, w, r}, 32'h5, "manager skips ap");
    chk(acc_paddr, 32'h00D00040, "manager pa");
    wcfg(2'h0, 32'h01E00000, 4'h0, 8'h02);
    acc(32'h00E00000, 3'h2);
    chk({30'h0, r}, 32'h2, "read-only write");
    acc(32'h00E00004, 3'h0);
    chk(acc_paddr, 32'h01E00004, "read-only read");
    wcfg(2'h0, 32'h00F00000, 4'h0, 8'h01);
    acc(32'h00F00000, 3'h0);
    chk({30'h0, r}, 32'h2, "privileged only");
    acc(32'h00F00008, 3'h3);
    chk({29'h0, w, r}, 32'h1, "privileged write");
    $display("t_perm done");
  endtask
  task automatic t_purge();
    wcfg(2'h0, 32'hABC00000, 4'h0, 8'hFF);
    cp(8'hF6, 1'b1, 32'h00101234);
    acc(32'h00101234, 3'h0);
    chk({29'h0, w, r}, 32'h5, "purged walks");
    acc(32'h00203456, 3'h0);
    chk({29'h0, w, r}, 32'h1, "other kept");
    cp(8'hF5, 1'b1, 32'h0);
    acc(32'h00203456, 3'h0);
    chk({29'h0, w, r}, 32'h5, "flushed walks");
    $display("t_purge done");
  endtask
  task automatic t_rr();
    walker_u.dly = 4'h0;
    for (int k = 0; k < 65; k++)
      acc({4'h8, 8'(k), 20'h0}, 3'h0);
    acc(32'h80100000, 3'h0);
    chk({29'h0, w, r}, 32'h1, "second fill kept");
    acc(32'h80000000, 3'h0);
    chk({29'h0, w, r}, 32'h5, "first fill replaced");
    $display("t_rr done");
  endtask
  task automatic t_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    chk({30'h0, cache_enable, wbuf_enable}, 32'h0, "reset enables");
    acc(32'h80100000, 3'h0);
    chk({29'h0, w, r}, 32'h1, "reset bypass");
    cp(8'hF1, 1'b1, 32'h00000001);
    cp(8'hF3, 1'b1, 32'h00000001);
    acc(32'h80100000, 3'h0);
    chk({29'h0, w, r}, 32'h5, "reset invalidates");
    chk(acc_paddr, 32'hABC00000, "refill pa");
    $display("t_reset done");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    t_boot();
    t_regs();
    t_map();
    t_fault();
    t_perm();
    t_purge();
    t_rr();
    t_reset();
    wrap_up();
  end
  initial begin
    #100us;
    mismatches++;
    wrap_up();
  end
endmodule
